// [hw/srw_top.sv]
// Notes on behaviour
// - Applied coarse delay steps toward written target.
// - Slow one, fast four LSBs per 256 cycles.
// - With slew on, each coarse write restarts ramp.
// - Reference edge must meet capture window deterministically.
// - Single-channel mode samples on both clock edges.
// - Detect reference position, capture on delayed clock.
// - Map valid after three reference rising edges.
// - Map bit one marks violation, zero valid.
// - Twenty-four positions, bit 0 smallest delay.
// - Map bits 0 and 23 read one.
// - Select field index picks delayed capture clock.
// - Select reaches only positions 0 to 15.
// - Phase step: zero coarse, one fine steps.
// - Clock invert delays by half a period.
// - All clocks shift by programmed aperture delay.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module srw_top
    import srw_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // AXI4-Lite write address and data
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Reference pin and delay-line tap samples
    input wire logic sysref_in,
    input wire logic [MAP_POSITIONS-1:0] tap_sample_in,
    // Clock path controls
    output logic [COARSE_W-1:0] coarse_delay_applied,
    output logic [FINE_W-1:0] fine_delay_setting,
    output logic clock_invert_delay,
    output logic dual_edge_sampling,
    output logic [SELECT_W-1:0] capture_phase_select,
    output logic phase_step_fine,
    output logic sysref_captured
);
    ////////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [DC_WIDTH-1:0] delay_ctrl_q;
    logic [CC_WIDTH-1:0] clock_ctrl_q;
    logic [COARSE_W-1:0] applied_q;
    logic [7:0] slew_cnt_q;
    logic [MAP_POSITIONS-1:0] map_raw;
    logic [MAP_POSITIONS-1:0] map_view;
    logic [1:0] edges_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    logic wr_fire;
    logic rd_fire;
    logic [7:0] wr_idx;
    logic [7:0] rd_idx;
    logic wr_aligned;
    logic rd_aligned;
    logic coarse_write;
    logic step_change;
    logic [COARSE_W-1:0] target;
    logic ramping;
    logic map_valid;
    logic [31:0] delay_merged;
    logic [COARSE_W-1:0] slew_step;
    logic [COARSE_W-1:0] slew_gap;

    assign target = delay_ctrl_q[DC_COARSE_LSB +: COARSE_W];

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write: address and data are taken together, one write at a time
    assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready = wr_fire;
    assign wr_idx = s_axi_awaddr[9:2];
    assign wr_aligned = (s_axi_awaddr[1:0] == 2'h0);

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction : merge

    assign delay_merged = merge({13'h0000, delay_ctrl_q}, s_axi_wdata, s_axi_wstrb);

    assign coarse_write = wr_fire && wr_aligned && (wr_idx == IDX_DELAY_CTRL) && s_axi_wstrb[0];

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            delay_ctrl_q <= DC_RESET;
        end else if (wr_fire && wr_aligned && (wr_idx == IDX_DELAY_CTRL)) begin
            delay_ctrl_q <= delay_merged[DC_WIDTH-1:0];
        end
    end

    // Changing the step size moves every position, so the gathered map is dropped
    assign step_change = wr_fire && wr_aligned && (wr_idx == IDX_CLOCK_CTRL) && s_axi_wstrb[0]
                         && (s_axi_wdata[CC_STEP_FINE_BIT] != clock_ctrl_q[CC_STEP_FINE_BIT]);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            clock_ctrl_q <= CC_RESET;
        end else if (wr_fire && wr_aligned && (wr_idx == IDX_CLOCK_CTRL) && s_axi_wstrb[0]) begin
            clock_ctrl_q <= s_axi_wdata[CC_WIDTH-1:0];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            if (wr_aligned && ((wr_idx == IDX_DELAY_CTRL) || (wr_idx == IDX_CLOCK_CTRL))) begin
                bresp_q <= RESP_OKAY;
            end else begin
                bresp_q <= RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read
    assign rd_fire = s_axi_arvalid && !rvalid_q;
    assign s_axi_arready = rd_fire;
    assign rd_idx = s_axi_araddr[9:2];
    assign rd_aligned = (s_axi_araddr[1:0] == 2'h0);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            if (!rd_aligned) begin
                rdata_q <= 32'h00000000;
                rresp_q <= RESP_SLVERR;
            end else if (rd_idx == IDX_DELAY_CTRL) begin
                rdata_q <= {13'h0000, delay_ctrl_q};
            end else if (rd_idx == IDX_CLOCK_CTRL) begin
                rdata_q <= {26'h0000000, clock_ctrl_q};
            end else if (rd_idx == IDX_STATUS) begin
                rdata_q <= {20'h00000, edges_q, map_valid, ramping, applied_q};
            end else if (rd_idx == IDX_MAP_LOW) begin
                rdata_q <= {24'h000000, map_view[7:0]};
            end else if (rd_idx == IDX_MAP_MID) begin
                rdata_q <= {24'h000000, map_view[15:8]};
            end else if (rd_idx == IDX_MAP_HIGH) begin
                rdata_q <= {24'h000000, map_view[23:16]};
            end else begin
                rdata_q <= 32'h00000000;
                rresp_q <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    ////////////////////////////////////////////////////////////////////////////
    // Coarse delay slew
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            slew_cnt_q <= 8'h00;
        end else if (coarse_write) begin
            slew_cnt_q <= 8'h00;
        end else begin
            slew_cnt_q <= slew_cnt_q + 8'h01;
        end
    end

    // Step for this tick, trimmed so the last step lands on the target
    always_comb begin
        slew_gap = (target > applied_q) ? (target - applied_q) : (applied_q - target);
        slew_step = delay_ctrl_q[DC_SLEW_FAST_BIT] ? SLEW_STEP_FAST : SLEW_STEP_SLOW;
        if (slew_gap < slew_step) begin
            slew_step = slew_gap;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            applied_q <= 8'h00;
        end else if (!delay_ctrl_q[DC_SLEW_EN_BIT]) begin
            applied_q <= target;
        end else if ((slew_cnt_q == 8'(SLEW_PERIOD_CYC - 1)) && (applied_q != target)) begin
            if (target > applied_q) begin
                applied_q <= applied_q + slew_step;
            end else begin
                applied_q <= applied_q - slew_step;
            end
        end
    end

    assign ramping = (applied_q != target);

    ////////////////////////////////////////////////////////////////////////////
    // Reference and tap synchronisers
    logic sysref_s1_q;
    logic sysref_s2_q;
    logic sysref_s3_q;
    logic [MAP_POSITIONS-1:0] tap_s1_q;
    logic [MAP_POSITIONS-1:0] tap_s2_q;
    logic sel_prev_q;
    logic ref_rise;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sysref_s1_q <= 1'b0;
            sysref_s2_q <= 1'b0;
            sysref_s3_q <= 1'b0;
            tap_s1_q <= 24'h000000;
            tap_s2_q <= 24'h000000;
        end else begin
            sysref_s1_q <= sysref_in;
            sysref_s2_q <= sysref_s1_q;
            sysref_s3_q <= sysref_s2_q;
            tap_s1_q <= tap_sample_in;
            tap_s2_q <= tap_s1_q;
        end
    end

    assign ref_rise = sysref_s2_q && !sysref_s3_q;

    ////////////////////////////////////////////////////////////////////////////
    // Position detector
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            edges_q <= 2'h0;
        end else if (step_change) begin
            edges_q <= 2'h0;
        end else if (ref_rise && (edges_q != MAP_VALID_EDGES)) begin
            edges_q <= edges_q + 2'h1;
        end
    end

    assign map_valid = (edges_q == MAP_VALID_EDGES);

    for (genvar i = 0; i < MAP_POSITIONS; i++) begin : g_tap
        srw_tap_if tap_if ();
        assign tap_if.strobe = ref_rise;
        assign tap_if.clear = step_change;
        assign tap_if.here = tap_s2_q[i];
        assign tap_if.left = (i == 0) ? tap_s2_q[i] : tap_s2_q[(i == 0) ? 0 : i - 1];
        assign tap_if.right = (i == MAP_POSITIONS - 1) ? tap_s2_q[i] : tap_s2_q[(i == MAP_POSITIONS - 1) ? i : i + 1];
        assign map_raw[i] = tap_if.flag;
        srw_tap_judge u_judge (
            .mclk(mclk),
            .rstn(rstn),
            .tap(tap_if.judge)
        );
    end

    // End positions lack a neighbour on one side and always report a hazard
    assign map_view = {1'b1, map_raw[MAP_POSITIONS-2:1], 1'b1};

    ////////////////////////////////////////////////////////////////////////////
    // Capture on the selected delayed tap
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sel_prev_q <= 1'b0;
        end else begin
            sel_prev_q <= tap_s2_q[clock_ctrl_q[CC_SELECT_LSB +: SELECT_W]];
        end
    end

    // The reference is taken on the rising edge of the selected tap, even where the map flags a hazard
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sysref_captured <= 1'b0;
        end else begin
            sysref_captured <= tap_s2_q[clock_ctrl_q[CC_SELECT_LSB +: SELECT_W]] && !sel_prev_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock path outputs
    assign coarse_delay_applied = applied_q;
    assign fine_delay_setting = delay_ctrl_q[DC_FINE_LSB +: FINE_W];
    assign clock_invert_delay = delay_ctrl_q[DC_INVERT_BIT];
    assign dual_edge_sampling = clock_ctrl_q[CC_SINGLE_CH_BIT];
    assign capture_phase_select = clock_ctrl_q[CC_SELECT_LSB +: SELECT_W];
    assign phase_step_fine = clock_ctrl_q[CC_STEP_FINE_BIT];
endmodule : srw_top

// [include/srw_pkg.sv]
package srw_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_DELAY_CTRL = 8'h20;
    localparam logic [7:0] IDX_CLOCK_CTRL = 8'h21;
    localparam logic [7:0] IDX_STATUS = 8'h22;
    localparam logic [7:0] IDX_MAP_LOW = 8'h2c;
    localparam logic [7:0] IDX_MAP_MID = 8'h2d;
    localparam logic [7:0] IDX_MAP_HIGH = 8'h2e;

    // Delay control fields
    localparam int DC_COARSE_LSB = 0;
    localparam int DC_FINE_LSB = 8;
    localparam int DC_INVERT_BIT = 16;
    localparam int DC_SLEW_EN_BIT = 17;
    localparam int DC_SLEW_FAST_BIT = 18;
    localparam int DC_WIDTH = 19;
    localparam logic [18:0] DC_RESET = 19'h00000;

    // Clock control fields
    localparam int CC_SELECT_LSB = 0;
    localparam int CC_STEP_FINE_BIT = 4;
    localparam int CC_SINGLE_CH_BIT = 5;
    localparam int CC_WIDTH = 6;
    localparam logic [5:0] CC_RESET = 6'h00;

    // Status fields
    localparam int ST_APPLIED_LSB = 0;
    localparam int ST_RAMPING_BIT = 8;
    localparam int ST_MAP_VALID_BIT = 9;
    localparam int ST_EDGES_LSB = 10;

    // Widths and counts
    localparam int COARSE_W = 8;
    localparam int FINE_W = 8;
    localparam int SELECT_W = 4;
    localparam int MAP_POSITIONS = 24;
    localparam int SELECTABLE_POSITIONS = 16;
    localparam int SLEW_PERIOD_CYC = 256;
    localparam logic [7:0] SLEW_STEP_SLOW = 8'h01;
    localparam logic [7:0] SLEW_STEP_FAST = 8'h04;
    localparam logic [1:0] MAP_VALID_EDGES = 2'h3;

    // AXI4-Lite responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : srw_pkg

// [include/srw_tap_if.sv]
`timescale 1ns/1ps
interface srw_tap_if;
    logic strobe;
    logic clear;
    logic here;
    logic left;
    logic right;
    logic flag;

    modport judge (
        input strobe,
        input clear,
        input here,
        input left,
        input right,
        output flag
    );
    modport ctrl (
        output strobe,
        output clear,
        output here,
        output left,
        output right,
        input flag
    );
endinterface : srw_tap_if

// [hw/srw_tap_judge.sv]
`timescale 1ns/1ps
module srw_tap_judge
    import srw_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Tap samples and verdict
    srw_tap_if.judge tap
);
    logic prev_q;
    logic have_prev_q;
    logic flag_q;

    // Remember this tap's capture from the previous reference edge
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prev_q <= 1'b0;
            have_prev_q <= 1'b0;
        end else if (tap.clear) begin
            have_prev_q <= 1'b0;
        end else if (tap.strobe) begin
            prev_q <= tap.here;
            have_prev_q <= 1'b1;
        end
    end

    // A neighbour that disagrees, or a capture that moves between edges, marks a margin hazard
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            flag_q <= 1'b0;
        end else if (tap.clear) begin
            flag_q <= 1'b0;
        end else if (tap.strobe) begin
            if ((tap.here != tap.left) || (tap.here != tap.right) || (have_prev_q && (tap.here != prev_q))) begin
                flag_q <= 1'b1;
            end
        end
    end

    assign tap.flag = flag_q;
endmodule : srw_tap_judge

// [dv/srw_props.sv]
`timescale 1ns/1ps
module srw_props
    import srw_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Clock path
    input wire logic [MAP_POSITIONS-1:0] tap_sample_in,
    input wire logic [COARSE_W-1:0] coarse_delay_applied,
    input wire logic [SELECT_W-1:0] capture_phase_select,
    input wire logic sysref_captured
);
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    logic slew_q;
    logic fast_q;
    logic [COARSE_W-1:0] tgt_q;
    logic [COARSE_W-1:0] prev_q;
    logic [7:0] gap_q;
    logic [7:0] wgap_q;
    logic ch;
    logic dwr;
    logic [COARSE_W-1:0] diff;
    logic [COARSE_W-1:0] rem;
    assign ch = coarse_delay_applied != prev_q;
    assign dwr = s_axi_awvalid && s_axi_awready && s_axi_awaddr == ADDR_W'(4 * IDX_DELAY_CTRL);
    assign diff = coarse_delay_applied > prev_q ? coarse_delay_applied - prev_q : prev_q - coarse_delay_applied;
    assign rem = tgt_q > prev_q ? tgt_q - prev_q : prev_q - tgt_q;
    // Shadow of the slew settings and target
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            slew_q <= 1'b0;
            fast_q <= 1'b0;
            tgt_q <= '0;
        end else if (dwr) begin
            slew_q <= s_axi_wdata[DC_SLEW_EN_BIT];
            fast_q <= s_axi_wdata[DC_SLEW_FAST_BIT];
            tgt_q <= s_axi_wdata[COARSE_W-1:0];
        end
    end
    // Cycles since the last step and since the last delay write, saturating
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prev_q <= '0;
            gap_q <= '0;
            wgap_q <= '0;
        end else begin
            prev_q <= coarse_delay_applied;
            gap_q <= ch ? 8'h00 : gap_q + {7'h00, gap_q != 8'hff};
            wgap_q <= dwr ? 8'h00 : wgap_q + {7'h00, wgap_q != 8'hff};
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_step_spacing: assert property (ch && slew_q |-> gap_q == 8'hff)
        else $error("ramp step sooner than 256 cycles after the last");
    a_write_restart: assert property (ch && slew_q |-> wgap_q == 8'hff)
        else $error("ramp step sooner than 256 cycles after a write");
    a_slow_step: assert property (ch && slew_q && !fast_q |-> diff == 8'h01)
        else $error("slow ramp step not one");
    a_fast_step: assert property (ch && slew_q && fast_q |-> diff == (rem > 8'h04 ? 8'h04 : rem))
        else $error("fast ramp step wrong size");
    a_no_overshoot: assert property (ch && slew_q |-> diff <= rem)
        else $error("ramp passed its target");
    a_capture_cause: assert property (sysref_captured |-> $past(tap_sample_in[capture_phase_select], 3))
        else $error("capture without the selected tap high");
    a_capture_pulse: assert property (sysref_captured |=> !sysref_captured)
        else $error("capture pulse longer than one cycle");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid && !s_axi_awready)
        else $error("write response missing");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
endmodule : srw_props

bind srw_top srw_props #(.ADDR_W(ADDR_W)) srw_props_i (.mclk, .rstn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wdata, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .tap_sample_in, .coarse_delay_applied, .capture_phase_select,
    .sysref_captured);

// [dv/srw_refgen.sv]
`timescale 1ns/1ps
module srw_refgen #(
    parameter logic [23:0] PATTERN = 24'h000ff0,
    parameter int HIGH_CYC = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Pulse request
    input wire logic fire,
    output logic busy,
    // Reference and tap samples
    output logic sysref_in,
    output logic [23:0] tap_sample_in
);
    logic [5:0] cnt_q;
    // Each pulse is high for HIGH_CYC cycles, then low as long
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) cnt_q <= '0;
        else if (fire && cnt_q == 6'h00) cnt_q <= 6'(2 * HIGH_CYC);
        else if (cnt_q != 6'h00) cnt_q <= cnt_q - 6'h01;
    end
    // Edges leave just after mclk and hold for many cycles
    assign sysref_in = cnt_q > 6'(HIGH_CYC);
    assign tap_sample_in = sysref_in ? PATTERN : 24'h000000;
    assign busy = cnt_q != 6'h00;
endmodule : srw_refgen

// [dv/srw_top_tb.sv]
`timescale 1ns/1ps
module srw_top_tb
    import srw_pkg::*;
;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, capture_phase_select;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic sysref_in, clock_invert_delay, dual_edge_sampling, phase_step_fine, sysref_captured, fire, busy;
    logic [23:0] tap_sample_in;
    logic [7:0] coarse_delay_applied, fine_delay_setting;
    int mismatches = 0;
    int checks = 0;
    int caps = 0;
    logic slow_rr = 1'b0;
    always #5 mclk = ~mclk;
    srw_top #(.ADDR_W(10)) srw_top_i (.mclk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .sysref_in, .tap_sample_in,
        .coarse_delay_applied, .fine_delay_setting, .clock_invert_delay, .dual_edge_sampling,
        .capture_phase_select, .phase_step_fine, .sysref_captured);
    srw_refgen srw_refgen_i (.mclk, .rstn, .fire, .busy, .sysref_in, .tap_sample_in);
    always @(posedge mclk) begin
        if (sysref_captured === 1'b1) caps++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic cmp_r(input string nm, input logic [1:0] e, input logic [1:0] g);
        cmp(nm, {30'h0, e}, {30'h0, g});
    endtask : cmp_r
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    task automatic hang(input string nm);
        mismatches++;
        $display("ERROR %s expected handshake seen none", nm);
        give_verdict();
    endtask : hang
    // Address and data offered together; bready stays high throughout
    task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        do @(posedge mclk); while (s_axi_awready !== 1'b1 && ++n < 50);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge mclk); while (s_axi_bvalid !== 1'b1 && ++n < 50);
        if (n >= 50) hang("bvalid");
        cmp_r("bresp", er, s_axi_bresp);
    endtask : wr
    task automatic rd(input logic [9:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= !slow_rr;
        do @(posedge mclk); while (s_axi_arready !== 1'b1 && ++n < 50);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1 && ++n < 50);
        // A late rready keeps the answer standing for one extra cycle
        if (slow_rr) begin
            s_axi_rready <= 1'b1;
            @(posedge mclk);
        end
        if (n >= 50) hang("rvalid");
        cmp_r("rresp", er, s_axi_rresp);
        cmp($sformatf("rdata %h", a), e, s_axi_rdata & m);
    endtask : rd
    task automatic step_to(input logic [7:0] e);
        logic [7:0] s;
        int n;
        s = coarse_delay_applied;
        n = 0;
        do @(posedge mclk); while (coarse_delay_applied === s && ++n < 300);
        if (n >= 300) hang("ramp step");
        cmp("applied", {24'h0, e}, {24'h0, coarse_delay_applied});
    endtask : step_to
    task automatic pulse();
        int n;
        n = 0;
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
        do @(posedge mclk); while (busy && ++n < 50);
        if (n >= 50) hang("reference pulse");
        repeat (4) @(posedge mclk);
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, fire} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rd(10'h080, 32'hffffffff, 32'h0, RESP_OKAY);
        rd(10'h084, 32'hffffffff, 32'h0, RESP_OKAY);
        rd(10'h3fc, 32'hffffffff, 32'h0, RESP_SLVERR);
        wr(10'h088, 32'hff, RESP_SLVERR);
        wr(10'h0b0, 32'hff, RESP_SLVERR);
        wr(10'h081, 32'hff, RESP_SLVERR);
        rd(10'h080, 32'hffffffff, 32'h0, RESP_OKAY);
        $display("test registers done");
        wr(10'h084, 32'h25, RESP_OKAY);
        cmp("select", 32'h5, {28'h0, capture_phase_select});
        cmp("dual edge", 32'h1, {31'h0, dual_edge_sampling});
        wr(10'h084, 32'h15, RESP_OKAY);
        cmp("step fine", 32'h1, {31'h0, phase_step_fine});
        wr(10'h080, 32'h12210, RESP_OKAY);
        @(posedge mclk);
        cmp("direct", 32'h12210, {15'h0, clock_invert_delay, fine_delay_setting, coarse_delay_applied});
        $display("test clock controls done");
        wr(10'h080, 32'h20012, RESP_OKAY);
        repeat (250) @(posedge mclk);
        cmp("applied", 32'h10, {24'h0, coarse_delay_applied});
        step_to(8'h11);
        step_to(8'h12);
        repeat (300) @(posedge mclk);
        cmp("applied", 32'h12, {24'h0, coarse_delay_applied});
        wr(10'h080, 32'h60020, RESP_OKAY);
        step_to(8'h16);
        step_to(8'h1a);
        wr(10'h080, 32'h6001b, RESP_OKAY);
        step_to(8'h1b);
        rd(10'h088, 32'h1ff, 32'h1b, RESP_OKAY);
        $display("test ramp done");
        pulse();
        pulse();
        rd(10'h088, 32'he00, 32'h800, RESP_OKAY);
        pulse();
        rd(10'h088, 32'he00, 32'he00, RESP_OKAY);
        slow_rr = 1'b1;
        rd(10'h0b0, 32'hff, 32'h19, RESP_OKAY);
        slow_rr = 1'b0;
        rd(10'h0b4, 32'hff, 32'h18, RESP_OKAY);
        rd(10'h0b8, 32'hff, 32'h80, RESP_OKAY);
        cmp("captures", 32'h3, caps);
        wr(10'h084, 32'h17, RESP_OKAY);
        pulse();
        cmp("captures", 32'h4, caps);
        wr(10'h084, 32'h1d, RESP_OKAY);
        pulse();
        cmp("captures", 32'h4, caps);
        wr(10'h084, 32'h10, RESP_OKAY);
        cmp("select", 32'h0, {28'h0, capture_phase_select});
        $display("test reference done");
        give_verdict();
    end
endmodule : srw_top_tb
